// ===== logic/cmpc_pkg.sv
package cmpc_pkg;
    localparam int CMPC_ADDR_W = 8;
    localparam logic [CMPC_ADDR_W-1:0] CMPC_ADDR_CTRL0 = 8'h00;
    // bit positions of comparator_control_zero
    localparam int CMPC_BIT_ON = 7;
    localparam int CMPC_BIT_RESULT = 6;
    localparam int CMPC_BIT_PIN_EN = 5;
    localparam int CMPC_BIT_INVERT = 4;
    localparam int CMPC_BIT_UNUSED = 3;
    localparam int CMPC_BIT_SPEED = 2;
    localparam int CMPC_BIT_HYST = 1;
    localparam int CMPC_BIT_SYNC = 0;
    // values after any reset
    localparam logic CMPC_RST_ON = 1'h0;
    localparam logic CMPC_RST_PIN_EN = 1'h0;
    localparam logic CMPC_RST_INVERT = 1'h0;
    localparam logic CMPC_RST_SPEED = 1'h1;
    localparam logic CMPC_RST_HYST = 1'h0;
    localparam logic CMPC_RST_SYNC = 1'h0;
    localparam logic CMPC_RST_RESULT = 1'h0;
    localparam logic [7:0] CMPC_RST_CTRL0 = 8'h04;

    typedef struct packed {
        logic comparator_on;
        logic result_pin_enable;
        logic result_invert;
        logic speed_power_select;
        logic hysteresis_on;
        logic timer_sync_output;
        logic result;
        logic out;
        logic tclk_prev;
        logic [7:0] rdata;
    } cmpc_state_t;
endpackage : cmpc_pkg

// ===== logic/cmpc_ctrl0.sv
// Functional notes
// R1 - bit 7 switches the comparator on
// R2 - bit 6 reads result, meaning follows polarity
// R3 - bit 4 set inverts comparator output
// R4 - bit 5 routes result to output pin
// R5 - pin driven only if direction bit cleared
// R6 - pin routing independent of comparator on bit
// R7 - reset loads speed bit one, others zero
// R8 - bit 3 reads zero, writes ignored
// R9 - bit 2 selects normal or low power speed
// R10 - bit 1 enables input hysteresis
// R11 - bit 0 latches output on timer clock fall
//
// Decided for this implementation: the register addresses and the strobed register port.
module cmpc_ctrl0
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [cmpc_pkg::CMPC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // analog front end
    input wire logic compare_raw,
    output logic comparator_on,
    output logic speed_power_select,
    output logic hysteresis_on,
    // timer side
    input wire logic timer_clk_src,
    output logic timer_result,
    // output pin
    input wire logic port_direction_bit,
    output logic result_pin_out,
    output logic result_pin_oe
);
    import cmpc_pkg::*;

    cmpc_state_t s_r;
    cmpc_state_t s_nxt;
    logic hit;
    logic tclk_fall;
    logic polar;
    // bus qualifiers shared by the checks below
    logic wr_hit;
    logic rd_hit;

    assign hit = (reg_addr == CMPC_ADDR_CTRL0);
    assign wr_hit = reg_wr && hit;
    assign rd_hit = reg_rd && hit;
    assign tclk_fall = s_r.tclk_prev && !timer_clk_src;
    // a disabled comparator reads as a low raw compare, so only polarity shows
    assign polar = (s_r.comparator_on && compare_raw) ^ s_r.result_invert; // [R1] [R3]

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tclk_prev = timer_clk_src;
        s_nxt.rdata = 8'h00;
        // internal result follows the compare on every cycle
        s_nxt.result = polar; // [R2] [R3]
        if (s_r.timer_sync_output)
        begin
            // latch only on the falling edge so a timer counting on the rising edge sees no race
            if (tclk_fall)
            begin
                s_nxt.out = s_r.result; // [R11]
            end
        end
        else
        begin
            s_nxt.out = s_r.result; // [R11]
        end
        if (reg_wr && hit)
        begin
            s_nxt.comparator_on = reg_wdata[CMPC_BIT_ON]; // [R1]
            s_nxt.result_pin_enable = reg_wdata[CMPC_BIT_PIN_EN]; // [R4]
            s_nxt.result_invert = reg_wdata[CMPC_BIT_INVERT]; // [R3]
            s_nxt.speed_power_select = reg_wdata[CMPC_BIT_SPEED]; // [R9]
            s_nxt.hysteresis_on = reg_wdata[CMPC_BIT_HYST]; // [R10]
            s_nxt.timer_sync_output = reg_wdata[CMPC_BIT_SYNC]; // [R11]
        end
        if (reg_rd && hit)
        begin
            s_nxt.rdata[CMPC_BIT_ON] = s_r.comparator_on;
            s_nxt.rdata[CMPC_BIT_RESULT] = s_r.result; // [R2]
            s_nxt.rdata[CMPC_BIT_PIN_EN] = s_r.result_pin_enable;
            s_nxt.rdata[CMPC_BIT_INVERT] = s_r.result_invert;
            s_nxt.rdata[CMPC_BIT_UNUSED] = 1'h0; // [R8]
            s_nxt.rdata[CMPC_BIT_SPEED] = s_r.speed_power_select;
            s_nxt.rdata[CMPC_BIT_HYST] = s_r.hysteresis_on;
            s_nxt.rdata[CMPC_BIT_SYNC] = s_r.timer_sync_output;
        end
        if (srst)
        begin
            s_nxt.comparator_on = CMPC_RST_ON; // [R7]
            s_nxt.result_pin_enable = CMPC_RST_PIN_EN; // [R7]
            s_nxt.result_invert = CMPC_RST_INVERT; // [R7]
            s_nxt.speed_power_select = CMPC_RST_SPEED; // [R7]
            s_nxt.hysteresis_on = CMPC_RST_HYST; // [R7]
            s_nxt.timer_sync_output = CMPC_RST_SYNC; // [R7]
            s_nxt.result = CMPC_RST_RESULT;
            s_nxt.out = CMPC_RST_RESULT;
            s_nxt.tclk_prev = 1'h0;
            s_nxt.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk)
    begin
        s_r <= s_nxt;
    end

    assign reg_rdata = s_r.rdata;
    assign comparator_on = s_r.comparator_on;
    assign speed_power_select = s_r.speed_power_select; // [R9]
    assign hysteresis_on = s_r.hysteresis_on; // [R10]
    assign timer_result = s_r.out;
    assign result_pin_out = s_r.out; // [R4]
    // the on bit plays no part here, so switching off keeps the port override
    assign result_pin_oe = s_r.result_pin_enable && !port_direction_bit; // [R4] [R5] [R6]

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_on_write;
        reg_wr && hit |=> comparator_on == $past(reg_wdata[CMPC_BIT_ON]);
    endproperty
    a_on_write: assert property (p_on_write) else $error("on bit not taken from write"); // [R1]

    property p_result_plain;
        comparator_on && !s_r.result_invert && !(reg_wr && hit) |=> s_r.result == $past(compare_raw);
    endproperty
    a_result_plain: assert property (p_result_plain) else $error("plain result wrong"); // [R2]

    property p_result_invert;
        comparator_on && s_r.result_invert && !(reg_wr && hit) |=> s_r.result == !$past(compare_raw);
    endproperty
    a_result_invert: assert property (p_result_invert) else $error("inverted result wrong"); // [R3]

    property p_read_result;
        reg_rd && hit |=> reg_rdata[CMPC_BIT_RESULT] == $past(s_r.result) ##1 reg_rdata == 8'h00 || $past(reg_rd);
    endproperty
    a_read_result: assert property (p_read_result) else $error("read result wrong"); // [R2]

    property p_pin_off;
        !s_r.result_pin_enable |-> !result_pin_oe;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled"); // [R4]

    property p_pin_dir;
        s_r.result_pin_enable |-> result_pin_oe == !port_direction_bit;
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin enable ignores direction"); // [R5]

    property p_pin_indep;
        reg_wr && hit && reg_wdata[CMPC_BIT_PIN_EN] && !reg_wdata[CMPC_BIT_ON] && !port_direction_bit
            |=> !comparator_on && result_pin_oe;
    endproperty
    a_pin_indep: assert property (p_pin_indep) else $error("pin tied to on bit"); // [R6]

    property p_reset_vals;
        @(posedge clk) $past(srst) |-> speed_power_select && !comparator_on && !hysteresis_on
            && !s_r.result_pin_enable && !s_r.result_invert && !s_r.timer_sync_output;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // [R7]

    property p_unused_bit;
        reg_rd |=> !reg_rdata[CMPC_BIT_UNUSED];
    endproperty
    a_unused_bit: assert property (p_unused_bit) else $error("unused bit reads one"); // [R8]

    property p_speed_write;
        reg_wr && hit |=> speed_power_select == $past(reg_wdata[CMPC_BIT_SPEED]);
    endproperty
    a_speed_write: assert property (p_speed_write) else $error("speed bit not taken"); // [R9]

    property p_hyst_write;
        reg_wr && hit |=> hysteresis_on == $past(reg_wdata[CMPC_BIT_HYST]);
    endproperty
    a_hyst_write: assert property (p_hyst_write) else $error("hysteresis bit not taken"); // [R10]

    property p_sync_hold;
        s_r.timer_sync_output && !tclk_fall |=> $stable(timer_result);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync output moved off edge"); // [R11]

    property p_async_follow;
        !s_r.timer_sync_output |=> timer_result == $past(s_r.result);
    endproperty
    a_async_follow: assert property (p_async_follow) else $error("async output lags"); // [R11]

    property p_invert_write;
        wr_hit |=> s_r.result_invert == $past(reg_wdata[CMPC_BIT_INVERT]);
    endproperty
    a_invert_write: assert property (p_invert_write) else $error("polarity bit not taken"); // [R3]

    property p_pin_en_write;
        wr_hit |=> s_r.result_pin_enable == $past(reg_wdata[CMPC_BIT_PIN_EN]);
    endproperty
    a_pin_en_write: assert property (p_pin_en_write) else $error("pin enable bit not taken"); // [R4]

    property p_sync_write;
        wr_hit |=> s_r.timer_sync_output == $past(reg_wdata[CMPC_BIT_SYNC]);
    endproperty
    a_sync_write: assert property (p_sync_write) else $error("sync bit not taken"); // [R11]

    // the control byte stands until a mapped write replaces it
    property p_control_stable;
        !wr_hit |=> $stable(comparator_on) && $stable(s_r.result_pin_enable) && $stable(s_r.result_invert)
            && $stable(speed_power_select) && $stable(hysteresis_on) && $stable(s_r.timer_sync_output);
    endproperty
    a_control_stable: assert property (p_control_stable) else $error("control bit moved"); // [R1] [R9] [R10]

    property p_read_on;
        rd_hit |=> reg_rdata[CMPC_BIT_ON] == $past(comparator_on);
    endproperty
    a_read_on: assert property (p_read_on) else $error("on bit reads wrong"); // [R1]

    property p_read_pin_en;
        rd_hit |=> reg_rdata[CMPC_BIT_PIN_EN] == $past(s_r.result_pin_enable);
    endproperty
    a_read_pin_en: assert property (p_read_pin_en) else $error("pin enable bit reads wrong"); // [R4]

    property p_read_invert;
        rd_hit |=> reg_rdata[CMPC_BIT_INVERT] == $past(s_r.result_invert);
    endproperty
    a_read_invert: assert property (p_read_invert) else $error("polarity bit reads wrong"); // [R3]

    property p_read_speed;
        rd_hit |=> reg_rdata[CMPC_BIT_SPEED] == $past(speed_power_select);
    endproperty
    a_read_speed: assert property (p_read_speed) else $error("speed bit reads wrong"); // [R9]

    property p_read_hyst;
        rd_hit |=> reg_rdata[CMPC_BIT_HYST] == $past(hysteresis_on);
    endproperty
    a_read_hyst: assert property (p_read_hyst) else $error("hysteresis bit reads wrong"); // [R10]

    property p_read_sync;
        rd_hit |=> reg_rdata[CMPC_BIT_SYNC] == $past(s_r.timer_sync_output);
    endproperty
    a_read_sync: assert property (p_read_sync) else $error("sync bit reads wrong"); // [R11]

    // read data is registered and shows only in the cycle after a mapped read
    property p_rdata_idle;
        !rd_hit |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // [R8]

    // switched off, the result shows the polarity bit alone
    property p_off_result;
        !comparator_on |=> s_r.result == $past(s_r.result_invert);
    endproperty
    a_off_result: assert property (p_off_result) else $error("result not forced while off"); // [R1]

    property p_sync_update;
        s_r.timer_sync_output && $past(timer_clk_src) && !timer_clk_src
            |=> timer_result == $past(s_r.result) && result_pin_out == $past(s_r.result);
    endproperty
    a_sync_update: assert property (p_sync_update) else $error("sync output missed timer fall"); // [R11]

    property p_sync_pin_hold;
        s_r.timer_sync_output && !($past(timer_clk_src) && !timer_clk_src) |=> $stable(result_pin_out);
    endproperty
    a_sync_pin_hold: assert property (p_sync_pin_hold) else $error("sync pin moved off edge"); // [R11]

    property p_pin_follow;
        !s_r.timer_sync_output |=> result_pin_out == $past(s_r.result);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("async pin lags"); // [R4] [R11]

    // end to end: raw compare reaches the pin two edges later
    property p_raw_to_pin;
        comparator_on && !s_r.result_invert ##1 !s_r.timer_sync_output
            |=> result_pin_out == $past(compare_raw, 2);
    endproperty
    a_raw_to_pin: assert property (p_raw_to_pin) else $error("plain pin path wrong"); // [R2] [R4]

    property p_raw_to_pin_inv;
        comparator_on && s_r.result_invert ##1 !s_r.timer_sync_output
            |=> result_pin_out == !$past(compare_raw, 2);
    endproperty
    a_raw_to_pin_inv: assert property (p_raw_to_pin_inv) else $error("inverted pin path wrong"); // [R3] [R4]

    property p_reset_outputs;
        $past(srst) |-> !timer_result && !result_pin_out && !result_pin_oe && reg_rdata == 8'h00;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared by reset"); // [R7]

    property p_dir_blocks;
        port_direction_bit |-> !result_pin_oe;
    endproperty
    a_dir_blocks: assert property (p_dir_blocks) else $error("pin driven while set as input"); // [R5]

    property p_off_pin;
        s_r.result_pin_enable && !comparator_on && !port_direction_bit |-> result_pin_oe;
    endproperty
    a_off_pin: assert property (p_off_pin) else $error("pin released while off"); // [R6]

    c_pin_driven: cover property (result_pin_oe && result_pin_out);
    c_sync_edge: cover property (s_r.timer_sync_output && tclk_fall ##1 $changed(timer_result));
    c_inverted: cover property (comparator_on && s_r.result_invert && s_r.result);
    c_read: cover property (reg_rd && hit ##1 reg_rdata[CMPC_BIT_ON]);
    c_off_pin: cover property (!comparator_on && result_pin_oe);
endmodule : cmpc_ctrl0

// ===== sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import cmpc_pkg::*;

    logic clk = 1'h0;
    logic srst = 1'h1;
    logic [CMPC_ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic compare_raw = 1'h0;
    logic comparator_on;
    logic speed_power_select;
    logic hysteresis_on;
    logic timer_clk_src = 1'h0;
    logic timer_result;
    logic port_direction_bit = 1'h0;
    logic result_pin_out;
    logic result_pin_oe;
    logic [7:0] rd;
    int fails = 0;
    int checks = 0;
    // write data beside expected readback; raw input stays low so bit 6 shows the polarity bit
    logic [15:0] rows [5] = '{16'hFFF7, 16'h4800, 16'hB5F5, 16'h1050, 16'h2020};

    cmpc_ctrl0 cmpc_ctrl0_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_raw(compare_raw),
        .comparator_on(comparator_on), .speed_power_select(speed_power_select),
        .hysteresis_on(hysteresis_on), .timer_clk_src(timer_clk_src), .timer_result(timer_result),
        .port_direction_bit(port_direction_bit), .result_pin_out(result_pin_out),
        .result_pin_oe(result_pin_oe));

    initial
    begin
        forever #25 clk = ~clk;
    end

    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    initial
    begin
        #200000;
        fails++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        reg_read(CMPC_ADDR_CTRL0, rd);
        chk(rd, 8'h04);
        for (int i = 0; i < 5; i++)
        begin
            reg_write(CMPC_ADDR_CTRL0, rows[i][15:8]);
            reg_read(CMPC_ADDR_CTRL0, rd);
            chk(rd, rows[i][7:0]);
            chk({7'h00, comparator_on}, {7'h00, rows[i][15]});
            chk({6'h00, speed_power_select, hysteresis_on}, {6'h00, rows[i][10:9]});
            chk({7'h00, result_pin_oe}, {7'h00, rows[i][13]});
        end
        // unmapped address must neither store nor answer
        reg_write(8'h01, 8'hFF);
        reg_read(CMPC_ADDR_CTRL0, rd);
        chk(rd, 8'h20);
        reg_read(8'h01, rd);
        chk(rd, 8'h00);
        @(posedge clk);
        compare_raw <= 1'h1;
        reg_write(CMPC_ADDR_CTRL0, 8'hA0);
        cycles(3);
        chk({6'h00, timer_result, result_pin_out}, 8'h03);
        reg_read(CMPC_ADDR_CTRL0, rd);
        chk(rd, 8'hE0);
        @(posedge clk);
        port_direction_bit <= 1'h1;
        cycles(1);
        chk({7'h00, result_pin_oe}, 8'h00);
        reg_write(CMPC_ADDR_CTRL0, 8'hB0);
        cycles(3);
        chk({7'h00, result_pin_out}, 8'h00);
        @(posedge clk);
        compare_raw <= 1'h0;
        cycles(3);
        chk({7'h00, result_pin_out}, 8'h01);
        // sync mode: output must hold until the timer clock falls
        reg_write(CMPC_ADDR_CTRL0, 8'h81);
        cycles(4);
        chk({7'h00, timer_result}, 8'h01);
        @(posedge clk);
        timer_clk_src <= 1'h1;
        cycles(2);
        chk({7'h00, timer_result}, 8'h01);
        @(posedge clk);
        timer_clk_src <= 1'h0;
        cycles(4);
        chk({7'h00, timer_result}, 8'h00);
        @(posedge clk);
        srst <= 1'h1;
        cycles(2);
        @(posedge clk);
        srst <= 1'h0;
        reg_read(CMPC_ADDR_CTRL0, rd);
        chk(rd, 8'h04);
        chk({2'h0, comparator_on, speed_power_select, hysteresis_on, result_pin_oe, timer_result, result_pin_out},
            8'h10);
        complete_run();
    end
endmodule : testbench
